// >>> rtl/return_stack.sv
// Return address stack with push and pop
`timescale 1ns/1ps
`include "srr_defines.svh"
module return_stack (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic pop,
  input wire srr_pkg::pc_t push_value,
  output srr_pkg::pc_t top
);
  import srr_pkg::*;
  pc_t mem_q [`STACK_DEPTH];
  logic [`PTR_W-1:0] ptr_q;
  wire logic [`PTR_W-1:0] ptr_up = ptr_q + 5'h01;
  wire logic [`PTR_W-1:0] ptr_dn = ptr_q - 5'h01;
  assign top = (ptr_q == 5'h00) ? `PC_RST : mem_q[ptr_dn];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= 5'h00;
    end else if (push && ptr_q != 5'(`STACK_DEPTH)) begin
      mem_q[ptr_q] <= push_value;
      ptr_q <= ptr_up;
    end else if (pop && ptr_q != 5'h00) begin
      ptr_q <= ptr_dn;
    end
  end
endmodule // return_stack

// >>> rtl/rotate_unit.sv
// Byte rotate through carry and without carry
`timescale 1ns/1ps
`include "srr_defines.svh"
module rotate_unit (
  input wire srr_pkg::byte_t operand,
  input wire logic carry_in,
  input wire logic [1:0] kind,
  output srr_pkg::byte_t result,
  output logic carry_out
);
  import srr_pkg::*;
  assign result = (kind == 2'h0) ? {operand[6:0], carry_in} :
                  (kind == 2'h1) ? {carry_in, operand[7:1]} :
                  {operand[6:0], operand[7]};
  assign carry_out = (kind == 2'h1) ? operand[0] : operand[7];
endmodule // rotate_unit

// >>> rtl/srr_defines.svh
// Constants for the stack, return and rotate execution block
`ifndef SRR_DEFINES_SVH
`define SRR_DEFINES_SVH
`define OP_IDLE 16'h0000
`define OP_DISCARD 16'h0006
`define OP_STORE 16'h0005
`define OP_SOFT_RESET 16'h00ff
`define OP_IRQ_RET_HI 15'h0008
`define OP_SUB_RET_HI 15'h0009
`define OP_LIT_RET_HI 8'h0c
`define OP_CALL_HI 5'h1b
`define OP_SECOND_HI 4'hf
`define OP_RLC_HI 6'h0d
`define OP_RRC_HI 6'h0c
`define OP_RLN_HI 6'h11
`define PC_STEP 21'h000002
`define STACK_DEPTH 31
`define PTR_W 5
`define INDEXED_LIMIT 8'h5f
`define ST_C 0
`define ST_Z 2
`define ST_N 4
`define WREG_RST 8'h00
`define STATUS_RST 8'h00
`define BANK_SEL_RST 4'h0
`define EXT_EN_BIT 0
`define PC_RST 21'h000000
`define ADDR_RESP_OKAY 2'b00
`define ADDR_RESP_SLVERR 2'b10
`define REG_OP 5'h00
`define REG_CTRL 5'h04
`define REG_PC 5'h08
`define REG_TOP 5'h0c
`define REG_WREG 5'h10
`define REG_FILE 5'h14
`define REG_FADDR 5'h18
`endif

// >>> rtl/srr_pkg.sv
// Types for the stack, return and rotate execution block
package srr_pkg;
  typedef enum logic [1:0] {ST_DECODE, ST_IDLE_CYCLE, ST_HALT} seq_e;
  typedef logic [20:0] pc_t;
  typedef logic [7:0] byte_t;
endpackage

// >>> rtl/stack_return_rotate_exec.sv
// Execution of stack, return and rotate instructions with AXI4-Lite access
`timescale 1ns/1ps
`include "srr_defines.svh"
module stack_return_rotate_exec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import srr_pkg::*;

  // Architectural state
  pc_t pc_q;
  byte_t wreg_q, status_q, file_q;
  logic [3:0] bank_sel_q;
  byte_t shadow_working_q, shadow_status_q;
  logic [3:0] shadow_bank_select_q;
  byte_t pc_high_holding_latch_q, pc_upper_holding_latch_q;
  logic high_prio_global_irq_enable_q, low_prio_global_irq_enable_q;
  logic in_high_irq_q, extended_en_q;
  logic [11:0] file_addr_q;
  logic indexed_q;
  logic [15:0] op_q;
  logic op_pending_q;
  seq_e state_q;

  // Bus slave state
  logic aw_held_q, w_held_q;
  logic [4:0] waddr_q;
  logic [31:0] wdata_q;

  // Decode
  wire logic is_idle = op_q == `OP_IDLE || op_q[15:12] == `OP_SECOND_HI;
  wire logic is_discard = op_q == `OP_DISCARD;
  wire logic is_store = op_q == `OP_STORE;
  wire logic is_soft_reset = op_q == `OP_SOFT_RESET;
  wire logic is_irq_ret = op_q[15:1] == `OP_IRQ_RET_HI;
  wire logic is_sub_ret = op_q[15:1] == `OP_SUB_RET_HI;
  wire logic is_lit_ret = op_q[15:8] == `OP_LIT_RET_HI;
  wire logic is_call = op_q[15:11] == `OP_CALL_HI;
  wire logic is_rlc = op_q[15:10] == `OP_RLC_HI;
  wire logic is_rrc = op_q[15:10] == `OP_RRC_HI;
  wire logic is_rln = op_q[15:10] == `OP_RLN_HI;
  wire logic is_rot = is_rlc || is_rrc || is_rln;
  wire logic shadow_bit = op_q[0];
  wire logic dest_bit = op_q[9];
  wire logic bank_bit = op_q[8];
  wire logic exec = op_pending_q && state_q == ST_DECODE;
  wire logic two_cycle = is_call || is_irq_ret || is_sub_ret || is_lit_ret;

  wire pc_t stack_top;
  wire pc_t ret_addr = pc_q + `PC_STEP;
  wire pc_t call_target = ret_addr + {{9{op_q[10]}}, op_q[10:0], 1'b0};
  wire logic stack_push = exec && (is_store || is_call);
  wire logic stack_pop = exec && (is_discard || is_irq_ret || is_sub_ret || is_lit_ret);

  wire byte_t rot_result;
  wire logic rot_carry;
  wire logic [1:0] rot_kind = is_rlc ? 2'h0 : (is_rrc ? 2'h1 : 2'h2);

  return_stack u_stack (
    .aclk(aclk),
    .aresetn(aresetn && !(exec && is_soft_reset)),
    .push(stack_push),
    .pop(stack_pop),
    .push_value(ret_addr),
    .top(stack_top)
  );

  rotate_unit u_rot (
    .operand(file_q),
    .carry_in(status_q[`ST_C]),
    .kind(rot_kind),
    .result(rot_result),
    .carry_out(rot_carry)
  );

  wire logic use_indexed = !bank_bit && extended_en_q && op_q[7:0] <= `INDEXED_LIMIT;
  wire logic [11:0] rot_addr = bank_bit ? {bank_sel_q, op_q[7:0]} :
                               {{4{op_q[7]}}, op_q[7:0]};

  // Bus decode
  wire logic aw_take = awvalid && awready;
  wire logic w_take = wvalid && wready;
  wire logic aw_have = aw_held_q || aw_take;
  wire logic w_have = w_held_q || w_take;
  // Out-of-range addresses fold onto an unmapped index
  wire logic [4:0] aw_idx = (awaddr[31:5] == 27'h0) ? awaddr[4:0] : 5'h1f;
  wire logic [4:0] wa = aw_take ? aw_idx : waddr_q;
  wire logic [31:0] wd = w_take ? wdata : wdata_q;
  wire logic do_write = aw_have && w_have && !bvalid;
  wire logic wr_hit = awaddr[31:5] == 27'h0 || !aw_take;
  wire logic wr_op = do_write && wa == `REG_OP && !op_pending_q;
  wire logic wr_ctrl = do_write && wa == `REG_CTRL;
  wire logic wr_pc = do_write && wa == `REG_PC;
  wire logic wr_file = do_write && wa == `REG_FILE;
  // Holding latches written only by software
  wire logic wr_latch = do_write && wa == `REG_WREG;
  // Extended set enable written by software
  wire logic wr_ext = do_write && wa == `REG_FADDR;
  wire logic wr_ok = wa == `REG_OP || wa == `REG_CTRL || wa == `REG_PC ||
                     wa == `REG_FILE || wa == `REG_WREG || wa == `REG_FADDR;
  wire logic ar_take = arvalid && arready;
  wire logic [4:0] ra = araddr[4:0];
  wire logic ra_ok = araddr[31:5] == 27'h0 && ra[1:0] == 2'h0 && ra <= `REG_FADDR;
  // Read data select
  wire logic [31:0] rd_val;
  assign rd_val = (ra == `REG_OP) ? {15'h0, op_pending_q, op_q} :
    (ra == `REG_CTRL) ? {4'h0, bank_sel_q, status_q, 9'h0, state_q, in_high_irq_q,
                         high_prio_global_irq_enable_q,
                         low_prio_global_irq_enable_q, indexed_q, extended_en_q} :
    (ra == `REG_PC) ? {11'h0, pc_q} :
    (ra == `REG_TOP) ? {11'h0, stack_top} :
    (ra == `REG_WREG) ? {8'h0, pc_upper_holding_latch_q, pc_high_holding_latch_q,
                         wreg_q} :
    (ra == `REG_FILE) ? {24'h0, file_q} :
    {20'h0, file_addr_q};

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_DECODE;
      op_pending_q <= 1'b0;
      op_q <= `OP_IDLE;
    end else if (exec && is_soft_reset) begin
      state_q <= ST_DECODE;
      op_pending_q <= 1'b0;
      op_q <= `OP_IDLE;
    end else begin
      if (wr_op) begin
        op_q <= wd[15:0];
        op_pending_q <= 1'b1;
      end else if (exec && !two_cycle) begin
        op_pending_q <= 1'b0;
      end
      case (state_q)
        ST_DECODE: begin
          if (exec && two_cycle) begin
            state_q <= ST_IDLE_CYCLE;
          end
        end
        ST_IDLE_CYCLE: begin
          state_q <= ST_DECODE;
          op_pending_q <= 1'b0;
        end
        default: begin
          state_q <= ST_DECODE;
        end
      endcase
    end
  end

  // Program counter and registers
  always_ff @(posedge aclk) begin
    if (!aresetn || (exec && is_soft_reset)) begin
      pc_q <= `PC_RST;
      wreg_q <= `WREG_RST;
      status_q <= `STATUS_RST;
      bank_sel_q <= `BANK_SEL_RST;
      high_prio_global_irq_enable_q <= 1'b0;
      low_prio_global_irq_enable_q <= 1'b0;
      pc_high_holding_latch_q <= 8'h00;
      pc_upper_holding_latch_q <= 8'h00;
      file_q <= 8'h00;
      file_addr_q <= 12'h000;
      indexed_q <= 1'b0;
    end else if (wr_pc) begin
      pc_q <= wd[20:0];
    end else if (exec) begin
      if (is_idle || is_discard || is_store || is_rot) begin
        pc_q <= ret_addr;
      end
      if (is_call) begin
        pc_q <= call_target;
      end
      if (is_irq_ret || is_sub_ret || is_lit_ret) begin
        pc_q <= stack_top;
      end
      if (is_irq_ret) begin
        if (in_high_irq_q) begin
          high_prio_global_irq_enable_q <= 1'b1;
        end else begin
          low_prio_global_irq_enable_q <= 1'b1;
        end
      end
      if ((is_irq_ret || is_sub_ret) && shadow_bit) begin
        wreg_q <= shadow_working_q;
        status_q <= shadow_status_q;
        bank_sel_q <= shadow_bank_select_q;
      end
      if (is_lit_ret) begin
        wreg_q <= op_q[7:0];
      end
      if (is_rot) begin
        file_addr_q <= rot_addr;
        indexed_q <= use_indexed;
        if (dest_bit) begin
          file_q <= rot_result;
        end else begin
          wreg_q <= rot_result;
        end
        status_q[`ST_N] <= rot_result[7];
        status_q[`ST_Z] <= rot_result == 8'h00;
        if (!is_rln) begin
          status_q[`ST_C] <= rot_carry;
        end
      end
    end else if (wr_ctrl) begin
      wreg_q <= wd[7:0];
      status_q <= wd[15:8];
      bank_sel_q <= wd[19:16];
      high_prio_global_irq_enable_q <= wd[20];
      low_prio_global_irq_enable_q <= wd[21];
    end else if (wr_file) begin
      file_q <= wd[7:0];
    end else if (wr_latch) begin
      pc_high_holding_latch_q <= wd[15:8];
      pc_upper_holding_latch_q <= wd[23:16];
    end
  end

  // Shadow copies and mode bits loaded by software
  always_ff @(posedge aclk) begin
    if (!aresetn || (exec && is_soft_reset)) begin
      shadow_working_q <= `WREG_RST;
      shadow_status_q <= `STATUS_RST;
      shadow_bank_select_q <= `BANK_SEL_RST;
      in_high_irq_q <= 1'b0;
      extended_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      shadow_working_q <= wd[31:24];
      // Snapshot of status and bank select
      shadow_bank_select_q <= wd[22] ? bank_sel_q : shadow_bank_select_q;
      shadow_status_q <= wd[22] ? status_q : shadow_status_q;
      in_high_irq_q <= wd[23];
    end else if (wr_ext) begin
      extended_en_q <= wd[`EXT_EN_BIT];
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `ADDR_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 5'h00;
      wdata_q <= 32'h0;
    end else begin
      awready <= !aw_have && !bvalid && !awready;
      wready <= !w_have && !bvalid && !wready;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        waddr_q <= aw_idx;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= wdata;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= (wr_hit && wr_ok) ? `ADDR_RESP_OKAY : `ADDR_RESP_SLVERR;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `ADDR_RESP_OKAY;
    end else begin
      arready <= !rvalid && !arready && !ar_take;
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata <= ra_ok ? rd_val : 32'h0;
        rresp <= ra_ok ? `ADDR_RESP_OKAY : `ADDR_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // stack_return_rotate_exec

// >>> verification/srr_sva.sv
// Bus handshake checker for the execution block
`timescale 1ns/1ps
module srr_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_cause;
    $rose(rvalid) |-> $past(arvalid && arready);
  endproperty
  a_r_cause: assert property (p_r_cause) else $error("read answer uncaused");
  property p_aw_block;
    bvalid |-> !awready && !wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken early");
  property p_r_unmapped;
    arvalid && arready && araddr > 32'h18 |=> rresp == 2'b10 && rdata == 32'h0;
  endproperty
  a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read ok");
  property p_r_mapped;
    arvalid && arready && araddr <= 32'h18 && araddr[1:0] == 2'b00 |=> rresp == 2'b00;
  endproperty
  a_r_mapped: assert property (p_r_mapped) else $error("mapped read error");
  property p_b_done;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  c_write: cover property (bvalid && bready);
  c_bad_read: cover property (rvalid && rready && rresp == 2'b10);
  c_both: cover property (awvalid && awready && wvalid && wready);
endmodule // srr_sva
bind stack_return_rotate_exec srr_sva u_sva (.*);

// >>> verification/tb.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
`include "srr_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb;
  import srr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches = 0;
  int total_checks = 0;
  stack_return_rotate_exec u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'b000), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'b000), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb_, da, dw, db;
    {da, dw, db} = 3'b000;
    awaddr <= {27'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!db) begin
      @(negedge aclk);
      ta = awready && !da;
      tw = wready && !dw;
      tb_ = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb_) bready <= 1'b0;
      da = da | ta;
      dw = dw | tw;
      db = tb_;
    end
    @(posedge aclk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr, dr;
    dr = 1'b0;
    araddr <= {27'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dr) begin
      @(negedge aclk);
      ta = arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      dr = tr;
    end
    @(posedge aclk);
  endtask
  task automatic ck(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK("register", e, d & m)
  endtask
  task automatic wc(input logic [31:0] d);
    logic [1:0] r;
    wr(`REG_CTRL, d, r);
  endtask
  task automatic ex(input logic [15:0] op);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(`REG_OP, {16'h0, op}, r);
    n = 0;
    d = 32'h10000;
    while (d[16] !== 1'b0 && n < 20) begin
      rd(`REG_OP, d, r);
      n++;
    end
    `CHK("pending", 1'b0, d[16])
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    complete_run();
  end
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] v, res, st;
    logic c;
    byte_t vals[6];
    vals = '{8'h80, 8'h01, 8'h00, 8'hc3, 8'h5a, 8'h96};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(`REG_PC, 32'h124, r);
    `CHK("write okay", 2'b00, r)
    ex(`OP_STORE);
    ck(`REG_TOP, 32'h1fffff, 32'h126);
    ex(`OP_STORE);
    ex(`OP_DISCARD);
    ck(`REG_TOP, 32'h1fffff, 32'h126);
    ck(`REG_PC, 32'h1fffff, 32'h12a);
    wr(`REG_PC, 32'h1000, r);
    ex({`OP_CALL_HI, 11'h400});
    ck(`REG_TOP, 32'h1fffff, 32'h1002);
    ck(`REG_PC, 32'h1fffff, 32'h802);
    ex({`OP_CALL_HI, 11'h3ff});
    ck(`REG_PC, 32'h1fffff, 32'h1002);
    wc(32'ha506_1533);
    wr(`REG_WREG, 32'h00ab_cd00, r);
    ex(16'h0012);
    ck(`REG_PC, 32'h1fffff, 32'h804);
    ck(`REG_CTRL, 32'h0fff_0000, 32'h0615_0000);
    ck(`REG_WREG, 32'hffff_ffff, 32'h00ab_cd33);
    wc(32'ha507_1433);
    wc(32'ha547_1433);
    wc(32'ha502_0111);
    ex(16'h0013);
    ck(`REG_PC, 32'h1fffff, 32'h1002);
    ck(`REG_CTRL, 32'h0fff_0000, 32'h0714_0000);
    ck(`REG_WREG, 32'hffff_ffff, 32'h00ab_cda5);
    wc(32'ha582_0111);
    ex(16'h0010);
    ck(`REG_PC, 32'h1fffff, 32'h126);
    ck(`REG_CTRL, 32'h0000_000c, 32'h8);
    ck(`REG_WREG, 32'hffff_ffff, 32'h00ab_cd11);
    ex(`OP_STORE);
    wc(32'ha502_0111);
    ex(16'h0011);
    ck(`REG_CTRL, 32'h0fff_000c, 32'h0714_0004);
    ex(`OP_STORE);
    ex(16'h0c5a);
    ck(`REG_PC, 32'h1fffff, 32'h12a);
    ck(`REG_WREG, 32'hffff_ffff, 32'h00ab_cd5a);
    ex(`OP_IDLE);
    ex(16'hf123);
    ck(`REG_PC, 32'h1fffff, 32'h12e);
    ck(`REG_WREG, 32'hffff_ffff, 32'h00ab_cd5a);
    for (int k = 0; k < 6; k++) begin
      v = vals[k];
      c = k[0];
      wc({12'h0, 4'h2, 7'h0, c, 8'h0});
      wr(`REG_FILE, {24'h0, v}, r);
      case (k % 3)
        0: ex({`OP_RLC_HI, k >= 3, 1'b1, 8'h3c});
        1: ex({`OP_RRC_HI, k >= 3, 1'b1, 8'h3c});
        default: ex({`OP_RLN_HI, k >= 3, 1'b1, 8'h3c});
      endcase
      res = (k % 3 == 0) ? {v[6:0], c} : (k % 3 == 1) ? {c, v[7:1]} : {v[6:0], v[7]};
      st = {3'h0, res[7], 1'b0, res == 8'h0, 1'b0, (k % 3 == 0) ? v[7] : (k % 3 == 1) ? v[0] : c};
      ck(`REG_CTRL, 32'h00ff_0002, {8'h0, st, 16'h0});
      ck(`REG_WREG, 32'hff, (k >= 3) ? 32'h0 : {24'h0, res});
      ck(`REG_FILE, 32'hff, (k >= 3) ? {24'h0, res} : {24'h0, v});
      ck(`REG_FADDR, 32'hfff, 32'h23c);
    end
    wr(`REG_FADDR, 32'h1, r);
    `CHK("enable write", 2'b00, r)
    ex({`OP_RLC_HI, 1'b1, 1'b0, 8'h5f});
    ck(`REG_CTRL, 32'h3, 32'h3);
    ck(`REG_FADDR, 32'hfff, 32'h05f);
    ex({`OP_RLC_HI, 1'b1, 1'b0, 8'h60});
    ck(`REG_CTRL, 32'h3, 32'h1);
    ex(`OP_STORE);
    ex(`OP_SOFT_RESET);
    ck(`REG_PC, 32'h1fffff, 32'h0);
    ck(`REG_TOP, 32'h1fffff, 32'h0);
    ck(`REG_WREG, 32'hffff_ffff, 32'h0);
    ck(`REG_CTRL, 32'h0fff_000f, 32'h0);
    rd(5'h1c, d, r);
    `CHK("unmapped read", 2'b10, r)
    wr(5'h1c, 32'h1, r);
    `CHK("unmapped write", 2'b10, r)
    complete_run();
  end
endmodule // tb
